// file: eas_pkg.sv
// Shared constants and types for the event/action sequencer
package eas_pkg;
	localparam int CODE_W = 8;
	localparam int MAX_STATES = 20;
	localparam int IDX_W = 5;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_NSTATE = 12'h004;
	localparam logic [11:0] ADDR_TDUR = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [3:0] REGION_EVT = 4'h1;
	localparam logic [3:0] REGION_ACT = 4'h2;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [IDX_W-1:0] NSTATE_RST = 5'h00;
	localparam logic [31:0] TDUR_RST = 32'h0000_0000;
	localparam logic [CODE_W-1:0] EVT_FALSE = 8'h00;
	localparam logic [CODE_W-1:0] EVT_TRUE = 8'h01;
	localparam logic [CODE_W-1:0] EVT_AT_REF = 8'h04;
	localparam logic [CODE_W-1:0] EVT_TIMEOUT0 = 8'h1E;
	localparam logic [CODE_W-1:0] ACT_NONE = 8'h01;
	localparam logic [CODE_W-1:0] ACT_PRESET0 = 8'h0A;
	localparam logic [CODE_W-1:0] ACT_PRESET1 = 8'h0B;
	localparam logic [CODE_W-1:0] ACT_TIMER0 = 8'h1D;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCAN_TIME_NS = 1000;
	localparam int SCAN_CYCLES = (SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		SQ_IDLE = 3'b001,
		SQ_FETCH = 3'b010,
		SQ_EVAL = 3'b100
	} eas_state_e;
	typedef struct packed {
		logic [CODE_W-1:0] evt;
		logic [CODE_W-1:0] act;
	} eas_entry_s;
	typedef struct packed {
		logic valid;
		logic [CODE_W-1:0] code;
	} eas_action_s;
endpackage

// file: eas_code_mem.sv
// Event and action code arrays, one entry per state, two registered read ports
`timescale 1ns/1ps
module eas_code_mem #(
	parameter int DEPTH = 20,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic we_evt,
	input wire logic we_act,
	input wire logic [AW-1:0] waddr,
	input wire logic [eas_pkg::CODE_W-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output eas_pkg::eas_entry_s rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output eas_pkg::eas_entry_s rdata_b
);
	import eas_pkg::*;
	eas_entry_s mem_r [DEPTH];
	// Per-entry write enables, so each entry is its own small register
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		always_ff @(posedge clk) begin
			if (we_evt && waddr == AW'(i)) begin
				mem_r[i].evt <= wdata;
			end
			if (we_act && waddr == AW'(i)) begin
				mem_r[i].act <= wdata;
			end
		end
	end
	always_ff @(posedge clk) begin
		rdata_a <= (raddr_a < AW'(DEPTH)) ? mem_r[raddr_a] : '0;
		rdata_b <= (raddr_b < AW'(DEPTH)) ? mem_r[raddr_b] : '0;
	end
endmodule

// file: eas_timer.sv
// Timer 0: counts scan intervals down from a loaded duration
`timescale 1ns/1ps
module eas_timer #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic start,
	input wire logic stop,
	input wire logic [W-1:0] dur,
	output logic running,
	output logic expired
);
	logic [W-1:0] cnt_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (stop) begin
			running <= 1'b0;
			expired <= 1'b0;
		end else if (start) begin
			cnt_r <= dur;
			running <= 1'b1;
			expired <= 1'b0;
		end else if (running && tick) begin
			if (cnt_r == '0) begin
				running <= 1'b0;
				expired <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// file: eas_sequencer.sv
// Event/action sequencer with AHB-Lite register slave
// Behaviour
// - Each scan interval, only the current state's event is examined.
// - False event: no action, state kept until the next scan.
// - Start at state one, testing only event one until true.
// - Event n true issues action n, then event n+1 is tested.
// - Zero to twenty programmable states, each with event and action codes.
// - After the last state's action, return to state one.
// - Event and action codes live in two indexed arrays, written by software.
// - Actions: 1 none, 10 preset 0, 11 preset 1, 29 start timer 0.
// - Start-timer loads programmed duration; expiry satisfies the timeout event.
// - Runs only while enabled; events from internal or external conditions.
`timescale 1ns/1ps
module eas_sequencer #(
	parameter int SCAN_CYC = eas_pkg::SCAN_CYCLES,
	parameter int TIMER_W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic speed_at_ref,
	input wire logic ext_event,
	output eas_pkg::eas_action_s action,
	output logic preset_sel
);
	import eas_pkg::*;

	// Bus side state
	logic dp_wr_r;
	logic dp_rd_r;
	logic [11:0] dp_addr_r;
	logic en_r;
	logic [IDX_W-1:0] nstate_r;
	logic [TIMER_W-1:0] tdur_r;

	// Sequencer state
	eas_state_e st_r;
	eas_state_e st_nxt;
	logic [IDX_W-1:0] idx_r;
	logic [IDX_W-1:0] idx_nxt;
	logic [15:0] div_r;
	logic scan_tick_r;
	logic t_running;
	logic t_expired;
	eas_entry_s bus_ent;
	eas_entry_s seq_ent;

	// Data phase decode of the address registered in the address phase
	wire logic acc = hsel && hready && htrans[1];
	wire logic [3:0] dp_region = dp_addr_r[11:8];
	wire logic [IDX_W-1:0] dp_idx = dp_addr_r[IDX_W+1:2];
	wire logic dp_idx_ok = dp_idx < IDX_W'(MAX_STATES);
	wire logic hit_ctrl = dp_addr_r == ADDR_CTRL;
	wire logic hit_nstate = dp_addr_r == ADDR_NSTATE;
	wire logic hit_tdur = dp_addr_r == ADDR_TDUR;
	wire logic hit_stat = dp_addr_r == ADDR_STAT;
	wire logic hit_evt = dp_region == REGION_EVT && dp_addr_r[7:IDX_W+2] == '0 && dp_idx_ok;
	wire logic hit_act = dp_region == REGION_ACT && dp_addr_r[7:IDX_W+2] == '0 && dp_idx_ok;
	wire logic we_evt = dp_wr_r && hit_evt;
	wire logic we_act = dp_wr_r && hit_act;
	// Counts above twenty are clamped rather than refused
	wire logic [IDX_W-1:0] nstate_wr = (hwdata > 32'(MAX_STATES)) ?
		IDX_W'(MAX_STATES) : hwdata[IDX_W-1:0];
	wire logic [31:0] stat_word = {22'h0, t_expired, t_running, preset_sel,
		st_r == SQ_IDLE, 1'b0, idx_r};
	wire logic [31:0] rd_mux =
		hit_ctrl ? {31'h0, en_r} :
		hit_nstate ? {27'h0, nstate_r} :
		hit_tdur ? 32'(tdur_r) :
		hit_stat ? stat_word :
		hit_evt ? {24'h0, bus_ent.evt} :
		hit_act ? {24'h0, bus_ent.act} : 32'h0000_0000;

	// Address and data phase tracking; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
			dp_addr_r <= 12'h000;
		end else if (hready) begin
			dp_wr_r <= acc && hwrite;
			dp_rd_r <= acc && !hwrite;
			dp_addr_r <= haddr[11:0];
		end else begin
			dp_rd_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (acc && !hwrite) begin
			hreadyout <= 1'b0;
		end else if (dp_rd_r) begin
			hreadyout <= 1'b1;
			hrdata <= rd_mux;
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_r <= CTRL_EN_RST;
			nstate_r <= NSTATE_RST;
			tdur_r <= TIMER_W'(TDUR_RST);
		end else if (dp_wr_r) begin
			if (hit_ctrl) begin
				en_r <= hwdata[CTRL_EN_BIT];
			end
			if (hit_nstate) begin
				nstate_r <= nstate_wr;
			end
			if (hit_tdur) begin
				tdur_r <= hwdata[TIMER_W-1:0];
			end
		end
	end

	eas_code_mem #(
		.DEPTH(MAX_STATES),
		.AW(IDX_W)
	) u_mem (
		.clk(hclk),
		.we_evt(we_evt),
		.we_act(we_act),
		.waddr(dp_idx),
		.wdata(hwdata[CODE_W-1:0]),
		.raddr_a(haddr[IDX_W+1:2]),
		.rdata_a(bus_ent),
		.raddr_b(idx_r),
		.rdata_b(seq_ent)
	);

	// Scan interval divider, held in step with the enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 16'h0000;
			scan_tick_r <= 1'b0;
		end else if (!en_r || div_r == 16'(SCAN_CYC - 1)) begin
			div_r <= 16'h0000;
			scan_tick_r <= en_r;
		end else begin
			div_r <= div_r + 16'h0001;
			scan_tick_r <= 1'b0;
		end
	end

	// Event decode: only the fetched entry of the current state is looked at
	logic evt_true;
	always_comb begin
		case (seq_ent.evt)
			EVT_FALSE: evt_true = 1'b0;
			EVT_TRUE: evt_true = 1'b1;
			EVT_AT_REF: evt_true = speed_at_ref;
			EVT_TIMEOUT0: evt_true = t_expired;
			default: evt_true = ext_event;
		endcase
	end

	wire logic fire = st_r == SQ_EVAL && evt_true && en_r;
	wire logic last = idx_r + 1'b1 >= nstate_r;
	wire logic run_ok = en_r && nstate_r != '0;
	wire logic t_start = fire && seq_ent.act == ACT_TIMER0;

	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		case (st_r)
			SQ_IDLE: begin
				if (idx_r >= nstate_r) begin
					idx_nxt = '0;
				end else if (run_ok && scan_tick_r) begin
					st_nxt = SQ_FETCH;
				end
			end
			SQ_FETCH: st_nxt = SQ_EVAL;
			SQ_EVAL: begin
				st_nxt = SQ_IDLE;
				if (fire) begin
					idx_nxt = last ? '0 : idx_r + 1'b1;
				end
			end
			default: st_nxt = SQ_IDLE;
		endcase
		if (!en_r) begin
			st_nxt = SQ_IDLE;
			idx_nxt = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= SQ_IDLE;
			idx_r <= '0;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Action strobe and preset selection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			action <= '0;
			preset_sel <= 1'b0;
		end else begin
			action.valid <= fire;
			action.code <= fire ? seq_ent.act : action.code;
			if (fire && seq_ent.act == ACT_PRESET0) begin
				preset_sel <= 1'b0;
			end else if (fire && seq_ent.act == ACT_PRESET1) begin
				preset_sel <= 1'b1;
			end
		end
	end

	// Timer runs in scan intervals so long durations fit a modest counter
	eas_timer #(
		.W(TIMER_W)
	) u_tmr (
		.clk(hclk),
		.rst_n(hresetn),
		.tick(scan_tick_r),
		.start(t_start),
		.stop(!en_r),
		.dur(tdur_r),
		.running(t_running),
		.expired(t_expired)
	);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_single_eval: assert property (st_r == SQ_EVAL |=> st_r != SQ_EVAL)
		else $error("event examined twice in one scan");
	chk_false_holds: assert property (st_r == SQ_EVAL && !evt_true && en_r
		|=> idx_r == $past(idx_r) && !action.valid)
		else $error("false event changed state or acted");
	chk_disable_home: assert property (!en_r |=> idx_r == '0 && st_r == SQ_IDLE)
		else $error("disabled sequencer not at first state");
	chk_fire_advance: assert property (fire && !last
		|=> action.valid && idx_r == $past(idx_r) + 1'b1 && action.code == $past(seq_ent.act))
		else $error("action or advance wrong");
	chk_count_limit: assert property (nstate_r <= IDX_W'(MAX_STATES))
		else $error("state count above limit");
	chk_wrap_first: assert property (fire && last |=> idx_r == '0)
		else $error("no wrap after last state");
	chk_fetch_eval: assert property (st_r == SQ_FETCH && en_r |=> st_r == SQ_EVAL
		&& seq_ent == $past(u_mem.mem_r[idx_r]))
		else $error("entry not fetched for current state");
	chk_true_event: assert property (st_r == SQ_EVAL && en_r && seq_ent.evt == EVT_TRUE
		|=> action.valid)
		else $error("true event did not act");
	chk_preset_one: assert property (action.valid && action.code == ACT_PRESET1
		|-> preset_sel)
		else $error("preset 1 not selected");
	chk_timer_load: assert property (t_start |=> t_running && !t_expired
		&& u_tmr.cnt_r == $past(tdur_r))
		else $error("timer not loaded");
	chk_idle_off: assert property (!en_r |=> !action.valid ##1 !action.valid)
		else $error("action while disabled");
	chk_strobe_once: assert property (action.valid |=> !action.valid)
		else $error("action strobe longer than one cycle");
	chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	// Bus checks: writes never wait, read data comes from the data-phase decode
	chk_write_ready: assert property (acc && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	chk_read_data: assert property (dp_rd_r && !acc |=> hrdata == $past(rd_mux))
		else $error("read data not captured");

	// Cycles since the last scan tick; a disabled sequencer holds it at zero
	// A counter keeps the scan period check free of long repetitions
	logic [15:0] tick_gap_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_gap_r <= 16'h0000;
		end else if (scan_tick_r || !en_r) begin
			tick_gap_r <= 16'h0000;
		end else begin
			tick_gap_r <= tick_gap_r + 16'h0001;
		end
	end

	chk_tick_early: assert property (scan_tick_r |-> tick_gap_r >= 16'(SCAN_CYC - 1))
		else $error("scan tick came early");
	chk_tick_late: assert property (tick_gap_r <= 16'(SCAN_CYC))
		else $error("scan tick overdue");
	chk_eval_tick: assert property (fire |-> $past(scan_tick_r, 2))
		else $error("event acted outside a scan");
	chk_fetch_start: assert property (st_r == SQ_IDLE && scan_tick_r && run_ok
		&& idx_r < nstate_r |=> st_r == SQ_FETCH)
		else $error("scan tick did not fetch");
	chk_idle_empty: assert property (nstate_r == '0 && st_r == SQ_IDLE
		|=> st_r == SQ_IDLE)
		else $error("empty program left idle");
	chk_nstate_write: assert property (dp_wr_r && hit_nstate
		|=> nstate_r == $past(nstate_wr))
		else $error("state count not written");
	chk_false_code: assert property (st_r == SQ_EVAL && seq_ent.evt == EVT_FALSE
		|=> !action.valid)
		else $error("false code acted");
	chk_at_ref: assert property (st_r == SQ_EVAL && en_r && seq_ent.evt == EVT_AT_REF
		|=> action.valid == $past(speed_at_ref))
		else $error("at-reference event not followed");
	chk_ext_event: assert property (st_r == SQ_EVAL && en_r && ext_event
		&& seq_ent.evt != EVT_FALSE && seq_ent.evt != EVT_TRUE
		&& seq_ent.evt != EVT_AT_REF && seq_ent.evt != EVT_TIMEOUT0
		|=> action.valid)
		else $error("external event not followed");
	chk_preset_zero: assert property (action.valid && action.code == ACT_PRESET0
		|-> !preset_sel)
		else $error("preset 0 not selected");
	chk_timeout_evt: assert property (st_r == SQ_EVAL && en_r
		&& seq_ent.evt == EVT_TIMEOUT0 |=> action.valid == $past(t_expired))
		else $error("timeout event not followed");
	chk_timer_expire: assert property (en_r && t_running && scan_tick_r && !t_start
		&& u_tmr.cnt_r == '0 |=> t_expired)
		else $error("timer did not expire");
	chk_enable_write: assert property (dp_wr_r && hit_ctrl
		|=> en_r == $past(hwdata[CTRL_EN_BIT]))
		else $error("enable not written");
	chk_disable_timer: assert property (!en_r |=> !t_running && !t_expired)
		else $error("timer not stopped by disable");
	chk_code_held: assert property (!fire |=> action.code == $past(action.code))
		else $error("action code changed without an action");

	cov_wrap: cover property (fire && last && nstate_r > 5'h01);
	cov_timeout: cover property (fire && seq_ent.evt == EVT_TIMEOUT0);
	cov_preset1: cover property (action.valid && action.code == ACT_PRESET1);
	cov_false_scan: cover property (st_r == SQ_EVAL && !evt_true ##[1:200] st_r == SQ_EVAL);
	cov_disable_run: cover property (en_r && idx_r != '0 ##1 !en_r);
endmodule

// file: eas_drive_model.sv
// Drive main control model: runs preset references and reports reaching them
`timescale 1ns/1ps
module eas_drive_model #(
	parameter int SETTLE = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire eas_pkg::eas_action_s action,
	input wire logic preset_sel,
	output logic speed_at_ref
);
	import eas_pkg::*;
	int cnt_r;
	wire new_ref = action.valid && (action.code == ACT_PRESET0 || action.code == ACT_PRESET1);
	// A new reference drops the at-reference condition until the ramp settles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 0;
			speed_at_ref <= 1'b0;
		end else if (new_ref) begin
			cnt_r <= SETTLE;
			speed_at_ref <= 1'b0;
		end else if (cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
			speed_at_ref <= (cnt_r == 1);
		end
	end
endmodule

// file: test_event_action_sequencer.sv
// Self-checking bench for the event/action sequencer
`timescale 1ns/1ps
module test_event_action_sequencer;
	import eas_pkg::*;
	localparam int SCAN = 8;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0;
	logic ext_event = 0;
	logic hreadyout, hresp, preset_sel, speed_at_ref, last_v;
	logic [31:0] hrdata, rd;
	eas_action_s action;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] seen_q[$];
	int seen_t[$];
	logic [7:0] row_evt[4] = '{EVT_TRUE, EVT_AT_REF, EVT_TIMEOUT0, 8'h07};
	logic [7:0] row_act[4] = '{ACT_PRESET0, ACT_TIMER0, ACT_PRESET1, ACT_NONE};
	logic [11:0] reg_a[4] = '{ADDR_CTRL, ADDR_NSTATE, ADDR_TDUR, 12'h010};

	eas_sequencer #(.SCAN_CYC(SCAN), .TIMER_W(32)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .speed_at_ref(speed_at_ref), .ext_event(ext_event),
		.action(action), .preset_sel(preset_sel));
	eas_drive_model #(.SETTLE(20)) drive (.hclk(hclk), .hresetn(hresetn), .action(action),
		.preset_sel(preset_sel), .speed_at_ref(speed_at_ref));

	always #5 hclk = ~hclk;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("Checks run %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hangs are cut here; a bus that never answers ends the run
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	always @(posedge hclk) begin
		if (action.valid === 1'b1) begin
			seen_q.push_back(action.code);
			seen_t.push_back(cyc);
			chk("strobe width", {31'h0, last_v}, 32'h0);
		end
		last_v <= action.valid;
	end

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wait_act(input int n);
		for (int i = 0; i < 2000 && seen_q.size() < n; i++) @(posedge hclk);
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset outputs", {20'h0, hreadyout, hresp, preset_sel, action}, 32'h800);
		chk("reset hrdata", hrdata, 32'h0);
		foreach (reg_a[i]) begin
			bus(1'b0, reg_a[i], 0);
			chk("reg reset", rd, 32'h0);
		end
		bus(1'b1, ADDR_NSTATE, 32'h15);
		bus(1'b0, ADDR_NSTATE, 0);
		chk("count clamp", rd, 32'h14);
		$display("done: reset and registers");
		foreach (row_evt[i]) begin
			bus(1'b1, {REGION_EVT, 8'(4 * i)}, {24'h0, row_evt[i]});
			bus(1'b1, {REGION_ACT, 8'(4 * i)}, {24'h0, row_act[i]});
			bus(1'b0, {REGION_EVT, 8'(4 * i)}, 0);
			chk("event array", rd, {24'h0, row_evt[i]});
			bus(1'b0, {REGION_ACT, 8'(4 * i)}, 0);
			chk("action array", rd, {24'h0, row_act[i]});
		end
		bus(1'b1, ADDR_NSTATE, 32'h4);
		bus(1'b1, ADDR_TDUR, 32'h2);
		bus(1'b1, ADDR_CTRL, 32'h1);
		wait_act(3);
		foreach (seen_q[i]) chk("action order", {24'h0, seen_q[i]}, {24'h0, row_act[i]});
		chk("preset one", {31'h0, preset_sel}, 32'h1);
		chk("timer wait", {31'h0, seen_t[2] - seen_t[1] >= 3 * SCAN}, 32'h1);
		repeat (4 * SCAN) @(posedge hclk);
		chk("false stall", seen_q.size(), 32'h3);
		bus(1'b0, ADDR_STAT, 0);
		chk("stall index", {27'h0, rd[4:0]}, 32'h3);
		$display("done: sequence");
		ext_event <= 1'b1;
		wait_act(5);
		ext_event <= 1'b0;
		chk("external event", {24'h0, seen_q[3]}, {24'h0, ACT_NONE});
		chk("wrap", {24'h0, seen_q[4]}, {24'h0, ACT_PRESET0});
		bus(1'b1, ADDR_CTRL, 32'h0);
		bus(1'b0, ADDR_STAT, 0);
		chk("disable index", {27'h0, rd[4:0]}, 32'h0);
		chk("disable expired", {31'h0, rd[9]}, 32'h0);
		bus(1'b1, ADDR_NSTATE, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h1);
		repeat (4 * SCAN) @(posedge hclk);
		chk("zero states", seen_q.size(), 32'h5);
		ext_event <= 1'b1;
		bus(1'b1, {REGION_EVT, 8'h00}, {24'h0, EVT_FALSE});
		bus(1'b1, ADDR_NSTATE, 32'h1);
		repeat (4 * SCAN) @(posedge hclk);
		chk("false code", seen_q.size(), 32'h5);
		ext_event <= 1'b0;
		bus(1'b1, ADDR_CTRL, 32'h0);
		$display("done: wrap, disable, empty program");
		end_of_test();
	end
endmodule
